/* hw/monitor_command_security.sv */
// Monitor-mode command interpreter with entry stacking and security gate
`timescale 1ns/1ps
`default_nettype none
module monitor_command_security
  import monitor_pkg::*;
(
  input  wire logic                     clk_sys_i,
  input  wire logic                     rst_b_i,
  input  wire logic                     por_i,
  input  wire logic                     mon_entry_i,
  input  wire monitor_pkg::cpu_frame_s  entry_frame_i,
  input  wire logic [15:0]              entry_sp_i,
  output logic                          run_o,
  output monitor_pkg::cpu_frame_s       run_frame_o,
  input  wire logic                     rx_valid_i,
  input  wire logic [7:0]               rx_data_i,
  output logic                          tx_valid_o,
  output logic                          tx_break_o,
  output logic [7:0]                    tx_data_o,
  input  wire logic                     tx_ready_i,
  output logic                          mem_req_o,
  output logic                          mem_we_o,
  output logic [15:0]                   mem_addr_o,
  output logic [7:0]                    mem_wdata_o,
  input  wire logic [7:0]               mem_rdata_i,
  input  wire logic                     mem_flash_i,
  input  wire logic                     mem_ack_i,
  input  wire logic                     bulk_erase_i,
  input  wire logic                     flash_fetch_i,
  output logic                          flash_unlocked_o,
  output logic                          illegal_addr_reset_o
);
  import monitor_pkg::*;

  mon_state_e  state_q, state_d, ret_q, ret_d;
  cpu_frame_s  frame_q, frame_d;
  logic [15:0] sp_q, sp_d, addr_q, addr_d, reply_q, reply_d;
  logic [15:0] maddr_q, maddr_d;
  logic [7:0]  op_q, op_d, echo_q, echo_d, wdata_q, wdata_d;
  logic [2:0]  idx_q, idx_d;
  logic        cnt_q, cnt_d, match_q, match_d, por_q, por_d;
  logic        unlocked_q, unlocked_d, run_q, run_d;
  logic [7:0]  rd_byte;

  // Byte of the frame at a given offset above SP
  function automatic logic [7:0] frame_byte(input cpu_frame_s f, input logic [2:0] off);
    case (off)
      OFF_X_HI:  frame_byte = f.x_hi;
      OFF_CC:    frame_byte = f.cc;
      OFF_ACC:   frame_byte = f.acc;
      OFF_X_LO:  frame_byte = f.x_lo;
      OFF_PC_HI: frame_byte = f.pc[15:8];
      OFF_PC_LO: frame_byte = f.pc[7:0];
      default:   frame_byte = INVALID_BYTE;
    endcase
  endfunction : frame_byte

  // Locked flash reads yield a fixed invalid value
  assign rd_byte = (mem_flash_i && !unlocked_q) ? INVALID_BYTE : mem_rdata_i;

  // Handshake and memory strobes decode from state
  assign tx_valid_o  = (state_q == ST_ECHO) || (state_q == ST_REPLY) || (state_q == ST_BREAK);
  assign tx_break_o  = (state_q == ST_BREAK);
  assign mem_req_o   = (state_q == ST_STACK) || (state_q == ST_SEC_RD) || (state_q == ST_FLAG) ||
                       (state_q == ST_WRITE) || (state_q == ST_READ) || (state_q == ST_PULL) ||
                       (state_q == ST_ERASE);
  assign mem_we_o    = (state_q == ST_STACK) || (state_q == ST_FLAG) || (state_q == ST_WRITE) ||
                       (state_q == ST_ERASE);
  assign mem_addr_o  = maddr_q;
  assign mem_wdata_o = wdata_q;
  assign tx_data_o   = (state_q == ST_REPLY) ? reply_q[15:8] : echo_q;
  assign run_o       = run_q;
  assign run_frame_o = frame_q;
  assign flash_unlocked_o     = unlocked_q;
  assign illegal_addr_reset_o = flash_fetch_i && !unlocked_q;

  // Next-state logic for the whole interpreter
  always_comb
  begin
    state_d    = state_q;
    ret_d      = ret_q;
    frame_d    = frame_q;
    sp_d       = sp_q;
    addr_d     = addr_q;
    reply_d    = reply_q;
    maddr_d    = maddr_q;
    op_d       = op_q;
    echo_d     = echo_q;
    wdata_d    = wdata_q;
    idx_d      = idx_q;
    cnt_d      = cnt_q;
    match_d    = match_q;
    por_d      = por_q;
    unlocked_d = unlocked_q;
    run_d      = 1'b0;
    case (state_q)
      ST_IDLE:
      begin
        if (mon_entry_i)
        begin
          // Software interrupt stacking, then index high pushed last
          frame_d = entry_frame_i;
          sp_d    = entry_sp_i;
          maddr_d = entry_sp_i;
          idx_d   = FRAME_LAST;
          wdata_d = frame_byte(entry_frame_i, FRAME_LAST);
          state_d = ST_STACK;
        end
      end
      ST_STACK:
      begin
        if (mem_ack_i)
        begin
          sp_d = sp_q - 16'h0001;
          if (idx_q == OFF_X_HI)
          begin
            idx_d   = 3'h0;
            match_d = 1'b1;
            state_d = por_q ? ST_SEC_RX : ST_BREAK;
          end
          else
          begin
            idx_d   = idx_q - 3'h1;
            maddr_d = sp_q - 16'h0001;
            wdata_d = frame_byte(frame_q, idx_q - 3'h1);
          end
        end
      end
      ST_SEC_RX:
      begin
        if (rx_valid_i)
        begin
          echo_d  = rx_data_i;
          maddr_d = SEC_BASE + {13'h0000, idx_q};
          ret_d   = ST_SEC_RD;
          state_d = ST_ECHO;
        end
      end
      ST_SEC_RD:
      begin
        if (mem_ack_i)
        begin
          // Raw compare; the lock gate does not apply to the comparator
          match_d = match_q && (mem_rdata_i == echo_q);
          idx_d   = idx_q + 3'h1;
          state_d = ST_SEC_RX;
          if (idx_q == SEC_LAST)
          begin
            unlocked_d = match_q && (mem_rdata_i == echo_q);
            maddr_d    = SEC_FLAG_ADDR;
            wdata_d    = 8'h00;
            wdata_d[SEC_FLAG_BIT] = match_q && (mem_rdata_i == echo_q);
            state_d    = ST_FLAG;
          end
        end
      end
      ST_FLAG:
      begin
        if (mem_ack_i)
          state_d = ST_BREAK;
      end
      ST_BREAK:
      begin
        if (tx_ready_i)
          state_d = ST_CMD;
      end
      ST_CMD:
      begin
        if (bulk_erase_i && !unlocked_q)
        begin
          // Erase after a failed attempt blanks every security byte
          idx_d   = 3'h0;
          maddr_d = SEC_BASE;
          wdata_d = ERASED_BYTE;
          state_d = ST_ERASE;
        end
        else if (rx_valid_i)
        begin
          op_d    = rx_data_i;
          echo_d  = rx_data_i;
          ret_d   = ST_CMD;
          state_d = ST_ECHO;
          case (rx_data_i)
            OP_IDX_WRITE:
              ret_d = ST_DATA;
            OP_IDX_READ:
            begin
              maddr_d = addr_q + 16'h0001;
              cnt_d   = 1'b0;
              ret_d   = ST_READ;
            end
            OP_STACK_READ:
            begin
              reply_d = sp_q + 16'h0001;
              cnt_d   = 1'b1;
              ret_d   = ST_REPLY;
            end
            OP_RUN:
            begin
              maddr_d = sp_q + 16'h0001;
              idx_d   = OFF_X_HI;
              ret_d   = ST_PULL;
            end
            default:
              ret_d = ST_CMD;
          endcase
        end
      end
      ST_ECHO:
      begin
        if (tx_ready_i)
          state_d = ret_q;
      end
      ST_DATA:
      begin
        if (rx_valid_i)
        begin
          echo_d  = rx_data_i;
          wdata_d = rx_data_i;
          maddr_d = addr_q + 16'h0001;
          ret_d   = ST_WRITE;
          state_d = ST_ECHO;
        end
      end
      ST_WRITE:
      begin
        if (mem_ack_i)
        begin
          addr_d  = maddr_q;
          state_d = ST_CMD;
        end
      end
      ST_READ:
      begin
        if (mem_ack_i)
        begin
          addr_d = maddr_q;
          if (!cnt_q)
          begin
            reply_d[15:8] = rd_byte;
            maddr_d       = maddr_q + 16'h0001;
            cnt_d         = 1'b1;
          end
          else
          begin
            reply_d[7:0] = rd_byte;
            state_d      = ST_REPLY;
          end
        end
      end
      ST_REPLY:
      begin
        if (tx_ready_i)
        begin
          reply_d = {reply_q[7:0], 8'h00};
          cnt_d   = 1'b0;
          if (!cnt_q)
            state_d = ST_CMD;
        end
      end
      ST_PULL:
      begin
        if (mem_ack_i)
        begin
          // Frame bytes may have been rewritten by the host
          case (idx_q)
            OFF_X_HI:  frame_d.x_hi     = mem_rdata_i;
            OFF_CC:    frame_d.cc       = mem_rdata_i;
            OFF_ACC:   frame_d.acc      = mem_rdata_i;
            OFF_X_LO:  frame_d.x_lo     = mem_rdata_i;
            OFF_PC_HI: frame_d.pc[15:8] = mem_rdata_i;
            default:   frame_d.pc[7:0]  = mem_rdata_i;
          endcase
          sp_d    = maddr_q;
          maddr_d = maddr_q + 16'h0001;
          idx_d   = idx_q + 3'h1;
          if (idx_q == OFF_PC_LO)
          begin
            run_d   = 1'b1;
            state_d = ST_IDLE;
          end
        end
      end
      ST_ERASE:
      begin
        if (mem_ack_i)
        begin
          idx_d   = idx_q + 3'h1;
          maddr_d = maddr_q + 16'h0001;
          if (idx_q == SEC_LAST)
            state_d = ST_CMD;
        end
      end
      default:
        state_d = ST_IDLE;
    endcase
    // Power-on clears the unlock; other resets leave it alone
    if (!rst_b_i)
    begin
      por_d = por_i;
      if (por_i)
        unlocked_d = 1'b0;
    end
  end

  // Register stage; unlock and reset cause are outside the reset branch
  always_ff @(posedge clk_sys_i)
  begin
    unlocked_q <= unlocked_d;
    por_q      <= por_d;
    if (!rst_b_i)
    begin
      state_q <= ST_IDLE;
      ret_q   <= ST_IDLE;
      frame_q <= '0;
      sp_q    <= ADDR_RESET;
      addr_q  <= ADDR_RESET;
      reply_q <= 16'h0000;
      maddr_q <= ADDR_RESET;
      op_q    <= 8'h00;
      echo_q  <= 8'h00;
      wdata_q <= 8'h00;
      idx_q   <= 3'h0;
      cnt_q   <= 1'b0;
      match_q <= 1'b0;
      run_q   <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      ret_q   <= ret_d;
      frame_q <= frame_d;
      sp_q    <= sp_d;
      addr_q  <= addr_d;
      reply_q <= reply_d;
      maddr_q <= maddr_d;
      op_q    <= op_d;
      echo_q  <= echo_d;
      wdata_q <= wdata_d;
      idx_q   <= idx_d;
      cnt_q   <= cnt_d;
      match_q <= match_d;
      run_q   <= run_d;
    end
  end
endmodule : monitor_command_security
`default_nettype wire

/* hw/monitor_pkg.sv */
// Shared constants and types for the monitor command interpreter
package monitor_pkg;
  localparam int          ADDR_W         = 16;
  localparam logic [7:0]  OP_IDX_WRITE   = 8'h19;
  localparam logic [7:0]  OP_IDX_READ    = 8'h1a;
  localparam logic [7:0]  OP_STACK_READ  = 8'h0c;
  localparam logic [7:0]  OP_RUN         = 8'h28;
  localparam logic [15:0] SEC_BASE       = 16'hfff6;
  localparam logic [2:0]  SEC_LAST       = 3'h7;
  localparam logic [7:0]  ERASED_BYTE    = 8'hff;
  localparam logic [7:0]  INVALID_BYTE   = 8'h00;
  localparam logic [15:0] SEC_FLAG_ADDR  = 16'h0040;
  localparam int          SEC_FLAG_BIT   = 6;
  localparam logic [2:0]  FRAME_LAST     = 3'h6;
  localparam logic [2:0]  OFF_X_HI       = 3'h1;
  localparam logic [2:0]  OFF_CC         = 3'h2;
  localparam logic [2:0]  OFF_ACC        = 3'h3;
  localparam logic [2:0]  OFF_X_LO       = 3'h4;
  localparam logic [2:0]  OFF_PC_HI      = 3'h5;
  localparam logic [2:0]  OFF_PC_LO      = 3'h6;
  localparam logic [15:0] ADDR_RESET     = 16'h0000;

  // CPU register frame saved at monitor entry and restored by run
  typedef struct packed {
    logic [7:0]  cc;
    logic [7:0]  acc;
    logic [7:0]  x_hi;
    logic [7:0]  x_lo;
    logic [15:0] pc;
  } cpu_frame_s;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0000,
    ST_STACK  = 4'b0001,
    ST_SEC_RX = 4'b0010,
    ST_SEC_RD = 4'b0011,
    ST_FLAG   = 4'b0100,
    ST_BREAK  = 4'b0101,
    ST_CMD    = 4'b0110,
    ST_ECHO   = 4'b0111,
    ST_DATA   = 4'b1000,
    ST_WRITE  = 4'b1001,
    ST_READ   = 4'b1010,
    ST_REPLY  = 4'b1011,
    ST_PULL   = 4'b1100,
    ST_ERASE  = 4'b1101
  } mon_state_e;
endpackage : monitor_pkg

/* bench/monitor_command_security_properties.sv */
// Port checker for the monitor command interpreter
`timescale 1ns/1ps
`default_nettype none
module monitor_checker
  import monitor_pkg::*;
(
  input wire logic        clk_sys_i,
  input wire logic        rst_b_i,
  input wire logic        por_i,
  input wire logic        run_o,
  input wire logic        tx_valid_o,
  input wire logic        tx_break_o,
  input wire logic [7:0]  tx_data_o,
  input wire logic        tx_ready_i,
  input wire logic        mem_req_o,
  input wire logic        mem_we_o,
  input wire logic [15:0] mem_addr_o,
  input wire logic [7:0]  mem_wdata_o,
  input wire logic        mem_ack_i,
  input wire logic        flash_fetch_i,
  input wire logic        flash_unlocked_o,
  input wire logic        illegal_addr_reset_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  logic flag_q;

  // Last flag bit stored; kept through reset, like the unlock flag
  always_ff @(posedge clk_sys_i)
    if (mem_req_o && mem_ack_i && mem_we_o && mem_addr_o == SEC_FLAG_ADDR)
      flag_q <= mem_wdata_o[SEC_FLAG_BIT];

  AST_TX_HOLD: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable({tx_break_o, tx_data_o}))
    else $error("transmit item changed before taken");
  AST_MEM_HOLD: assert property (mem_req_o && !mem_ack_i |=> mem_req_o && $stable({mem_we_o, mem_addr_o, mem_wdata_o}))
    else $error("memory request changed before ack");
  AST_ILLEGAL: assert property (illegal_addr_reset_o == (flash_fetch_i && !flash_unlocked_o))
    else $error("illegal address reset wrong");
  AST_UNLOCK_KEPT: assert property ($fell(flash_unlocked_o) |-> !$past(rst_b_i) && $past(por_i))
    else $error("unlock lost without power-on reset");
  AST_BREAK_FLAG: assert property (tx_valid_o && tx_break_o |-> flash_unlocked_o == flag_q)
    else $error("flag byte disagrees with unlock");
  AST_BREAK_QUIET: assert property (tx_break_o |-> tx_valid_o && !mem_req_o)
    else $error("break outside a finished sequence");
  AST_UNLOCK_BREAK: assert property ($rose(flash_unlocked_o) |-> ##[0:40] tx_valid_o && tx_break_o)
    else $error("no break after unlock");
  AST_RUN_PULSE: assert property (run_o |=> !run_o && !mem_req_o && !tx_valid_o)
    else $error("run not a single quiet pulse");

  COV_RUN: cover property (run_o);
  COV_BREAK: cover property (tx_valid_o && tx_break_o && tx_ready_i);
  COV_UNLOCK: cover property ($rose(flash_unlocked_o));
endmodule : monitor_checker

bind monitor_command_security monitor_checker u_checker (
  .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .por_i(por_i), .run_o(run_o), .tx_valid_o(tx_valid_o),
  .tx_break_o(tx_break_o),
  .tx_data_o(tx_data_o), .tx_ready_i(tx_ready_i), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o),
  .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .mem_ack_i(mem_ack_i), .flash_fetch_i(flash_fetch_i),
  .flash_unlocked_o(flash_unlocked_o), .illegal_addr_reset_o(illegal_addr_reset_o)
);
`default_nettype wire

/* bench/monitor_far_side.sv */
// Memory and transmitter model facing the interpreter
`timescale 1ns/1ps
`default_nettype none
module monitor_far_side (
  input  wire logic        clk_sys_i,
  input  wire logic        req_i,
  input  wire logic        we_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        txv_i,
  output logic [7:0]       rdata_o,
  output logic             flash_o,
  output logic             ack_o,
  output logic             ready_o
);
  logic [7:0] mem [0:65535];
  logic       slow_q = 1'b0;

  // Security bytes programmed, never left blank; others a fixed pattern
  initial
    for (int a = 0; a < 65536; a++)
      mem[a] = (a >= 32'h0000fff6 && a <= 32'h0000fffd) ? 8'(a - 32'h0000fff6) + 8'ha0 : 8'(a) ^ 8'h5a;

  // Odd addresses and alternate cycles answer late, so both speeds occur
  assign ack_o   = req_i && (slow_q || !addr_i[0]);
  assign ready_o = txv_i && slow_q;
  assign rdata_o = mem[addr_i];
  assign flash_o = addr_i[15];

  // Writes land on the acknowledging edge
  always @(posedge clk_sys_i)
  begin
    slow_q <= !slow_q;
    if (ack_o && we_i)
      mem[addr_i] <= wdata_i;
  end
endmodule : monitor_far_side
`default_nettype wire

/* bench/monitor_command_security_tb_top.sv */
// Self-checking bench for the monitor command interpreter
`timescale 1ns/1ps
`default_nettype none
module monitor_command_security_tb_top;
  import monitor_pkg::*;
  logic        clk_sys_i = 1'b0, rst_b_i = 1'b0, por_i = 1'b1, mon_entry_i = 1'b0, rx_valid_i = 1'b0;
  logic        bulk_erase_i = 1'b0, flash_fetch_i = 1'b0;
  logic [7:0]  rx_data_i = 8'h00;
  logic [15:0] entry_sp_i = 16'h01f0, seed = 16'h0041;
  cpu_frame_s  entry_frame_i = '0, run_frame_o;
  logic        run_o, tx_valid_o, tx_break_o, tx_ready_i, mem_req_o, mem_we_o, mem_flash_i, mem_ack_i;
  logic        flash_unlocked_o, illegal_addr_reset_o;
  logic [7:0]  tx_data_o, mem_wdata_o, mem_rdata_i;
  logic [15:0] mem_addr_o;
  logic [8:0]  exp_q [$];
  int          n_mismatch = 0, samples_checked = 0, n_run = 0;

  always #2 clk_sys_i = ~clk_sys_i;

  monitor_command_security dut (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .por_i(por_i), .mon_entry_i(mon_entry_i),
    .entry_frame_i(entry_frame_i), .entry_sp_i(entry_sp_i), .run_o(run_o), .run_frame_o(run_frame_o),
    .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i), .tx_valid_o(tx_valid_o), .tx_break_o(tx_break_o),
    .tx_data_o(tx_data_o), .tx_ready_i(tx_ready_i), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o),
    .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i), .mem_flash_i(mem_flash_i),
    .mem_ack_i(mem_ack_i), .bulk_erase_i(bulk_erase_i), .flash_fetch_i(flash_fetch_i),
    .flash_unlocked_o(flash_unlocked_o), .illegal_addr_reset_o(illegal_addr_reset_o)
  );
  monitor_far_side mdl (
    .clk_sys_i(clk_sys_i), .req_i(mem_req_o), .we_i(mem_we_o), .addr_i(mem_addr_o), .wdata_i(mem_wdata_o),
    .txv_i(tx_valid_o), .rdata_o(mem_rdata_i), .flash_o(mem_flash_i), .ack_o(mem_ack_i), .ready_o(tx_ready_i)
  );

  function automatic logic [15:0] xs();
    seed ^= seed << 7;
    seed ^= seed >> 9;
    seed ^= seed << 8;
    return seed;
  endfunction : xs

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask : tick

  task automatic final_report();
    $display("checks %0d, mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report

  // Bounded wait for noted replies, then time for memory traffic
  task automatic drain();
    for (int t = 0; t < 400 && exp_q.size() != 0; t++)
      tick(1);
    check(16'(exp_q.size()), 16'h0000);
    tick(12);
  endtask : drain

  // One host byte; its echo goes ahead of replies already noted
  task automatic send(input logic [7:0] b);
    exp_q.push_front({1'b0, b});
    rx_data_i <= b;
    rx_valid_i <= 1'b1;
    tick(1);
    rx_valid_i <= 1'b0;
    drain();
  endtask : send

  // Reset of either kind, then monitor entry with a random frame
  task automatic enter(input logic por, input int n);
    rst_b_i <= 1'b0;
    por_i <= por;
    tick(n);
    rst_b_i <= 1'b1;
    entry_frame_i <= cpu_frame_s'({xs(), xs(), xs()});
    entry_sp_i <= 16'h0100 | (xs() & 16'h00fe);
    tick(1);
    mon_entry_i <= 1'b1;
    tick(1);
    mon_entry_i <= 1'b0;
    if (!por)
      exp_q.push_back(9'h100);
    tick(20);
    drain();
  endtask : enter

  // Eight security bytes; the break is due only after the last
  task automatic code(input logic good);
    for (int i = 0; i < 8; i++)
    begin
      if (i == 7)
        exp_q.push_back(9'h100);
      send(good ? 8'ha0 + 8'(i) : 8'(xs()) & 8'h7f);
    end
  endtask : code

  // Each transmitted item is matched against the note at the front of the queue
  always @(posedge clk_sys_i)
  begin
    if (rst_b_i && tx_valid_o && tx_ready_i)
      check(tx_break_o ? 16'h0100 : {8'h00, tx_data_o}, exp_q.size() != 0 ? 16'(exp_q.pop_front()) : 16'hffff);
    if (run_o)
      n_run++;
  end

  initial
  begin
    logic [7:0]  d;
    logic [15:0] sp1;
    logic [47:0] f;
    enter(1'b1, 12);
    code(1'b1);
    check(16'(flash_unlocked_o), 16'h0001);
    check(16'(mdl.mem[SEC_FLAG_ADDR][SEC_FLAG_BIT]), 16'h0001);
    f = {entry_frame_i.x_hi, entry_frame_i.cc, entry_frame_i.acc, entry_frame_i.x_lo, entry_frame_i.pc};
    for (int k = 0; k < 6; k++)
      check(16'(mdl.mem[entry_sp_i - 16'h0005 + 16'(k)]), 16'(f[47-8*k -: 8]));
    // Six pushes leave SP+1 five below the entry value
    sp1 = entry_sp_i - 16'h0005;
    exp_q.push_back(9'(sp1[15:8]));
    exp_q.push_back(9'(sp1[7:0]));
    send(OP_STACK_READ);
    // Unknown opcode: only its echo comes back
    send(8'(xs()) | 8'h80);
    for (int i = 1; i < 3; i++)
    begin
      d = 8'(xs());
      send(OP_IDX_WRITE);
      send(d);
      check(16'(mdl.mem[i]), 16'(d));
    end
    exp_q.push_back(9'(mdl.mem[3]));
    exp_q.push_back(9'(mdl.mem[4]));
    send(OP_IDX_READ);
    // Host rewrites the stacked program counter before run
    f[15:0] = xs();
    mdl.mem[sp1 + 16'h0004] = f[15:8];
    mdl.mem[sp1 + 16'h0005] = f[7:0];
    send(OP_RUN);
    check(16'(n_run), 16'h0001);
    for (int k = 0; k < 2; k++)
      check(run_frame_o[47-16*k -: 16], entry_frame_i[47-16*k -: 16]);
    check(run_frame_o.pc, f[15:0]);
    enter(1'b0, 2);
    check(16'(flash_unlocked_o), 16'h0001);
    // Power-on retry with a wrong code leaves flash locked
    enter(1'b1, 1);
    code(1'b0);
    check(16'(flash_unlocked_o), 16'h0000);
    check(16'(mdl.mem[SEC_FLAG_ADDR][SEC_FLAG_BIT]), 16'h0000);
    flash_fetch_i <= 1'b1;
    tick(1);
    check(16'(illegal_addr_reset_o), 16'h0001);
    flash_fetch_i <= 1'b0;
    bulk_erase_i <= 1'b1;
    tick(1);
    bulk_erase_i <= 1'b0;
    tick(40);
    for (int a = 32'h0000fff6; a <= 32'h0000fffd; a++)
      check(16'(mdl.mem[a]), 16'(ERASED_BYTE));
    final_report();
  end

  // Watchdog at over thirty times the expected run length
  initial
  begin
    tick(20000);
    n_mismatch++;
    final_report();
  end
endmodule : monitor_command_security_tb_top
`default_nettype wire
